/* File: cause_select.sv */
`timescale 1ns/1ps
`include "sync_action_params.svh"

module cause_select
  import sync_action_pkg::*;
#(
  parameter int CAUSES = 16
) (
  input  wire logic [3:0]        cause_code,
  input  wire logic [CAUSES-1:0] cause_event,
  output logic                   cause_hit
);

  // Code 0 is NOP: the set only acts when chained or commanded
  wire logic is_nop = (cause_code == `CAUSE_NOP);
  wire logic in_rng = (32'(cause_code) < CAUSES);

  assign cause_hit = ~is_nop & in_rng & cause_event[cause_code];

endmodule : cause_select

/* File: fire_router.sv */
`timescale 1ns/1ps
`include "sync_action_params.svh"

module fire_router
  import sync_action_pkg::*;
(
  input  wire logic [3:0]        own_fire,
  input  wire set_cfg_type [3:0] cfg,
  output logic [3:0]             sibling_req,
  output logic [2:0]             cross_req
);

  // Rotate a sibling bit group so that bit j lands on set (k+1+j) mod 4
  function automatic logic [3:0] rotate_targets(input logic [2:0] bits, input logic [1:0] self);
    logic [3:0] wide;
    wide = {bits, 1'b0};
    return 4'((wide << self) | (wide >> (3'd4 - {1'b0, self})));
  endfunction : rotate_targets

  always_comb begin
    sibling_req = 4'h0;
    cross_req   = 3'h0;
    for (int k = 0; k < 4; k++) begin
      if (own_fire[k]) begin
        sibling_req = sibling_req | rotate_targets(cfg[k].sibling_fire_bits, 2'(k));
        cross_req   = cross_req | cfg[k].cross_axis_fire_bits;
      end
    end
  end

endmodule : fire_router

/* File: sync_action_params.svh */
// How it works
// - Config command latches write data word into set
// - Bits 3..0 hold activation cause code
// - Bits 8..4 hold action select code
// - Cause code 3h means drive start
// - Action code 17h starts split pulse
// - Bits 11..9 fire sibling sets cyclically
// - Bits 14..12 fire set 0 ahead
// - Bit 15 repeats; clear means once
// - Once-only set disables itself after acting
// - Repeating set stays enabled after acting
// - Only disable command or error with option breaks repeat loops
// - Enable commands 81h..8Fh set masked sets
// - Only enabled sets perform their action
// - Error flag with option disables all sets
// - Enables ignored until error clear command
// - Third status word bits 3..0 show enables
// - Disable commands 91h..9Fh; reset all disabled
// - Activation commands A1h..AFh fire enabled sets
// - Status bit one means set enabled
`ifndef SYNC_ACTION_PARAMS_SVH
`define SYNC_ACTION_PARAMS_SVH

`define OFF_WRITE_DATA     8'h00
`define OFF_COMMAND        8'h04
`define OFF_STATUS3        8'h08
`define OFF_BLOCK_STATUS   8'h0c
`define OFF_CFG_BASE       8'h10
`define OFF_CFG_LAST       8'h1c

`define CMD_PIN_CFG2       8'h22
`define CMD_CFG_BASE       8'h26
`define CMD_CFG_LAST       8'h29
`define CMD_ERR_CLEAR      8'h79
`define CMD_ENABLE_HI      4'h8
`define CMD_DISABLE_HI     4'h9
`define CMD_ACTIVATE_HI    4'ha

`define CAUSE_LSB          0
`define ACTION_LSB         4
`define SIBLING_LSB        9
`define AXIS_LSB           12
`define REPEAT_BIT         15
`define ERROR_DISABLES_SETS_BIT          7

`define CAUSE_NOP          4'h0
`define CAUSE_DRIVE_START  4'h3
`define ACTION_SPLIT_START 5'h17

`define CFG_RESET          16'h0000
`define WDATA_RESET        16'h0000
`define ENABLE_RESET       4'h0

`endif

/* File: sync_action_pkg.sv */
package sync_action_pkg;

  typedef struct packed {
    logic       repeat_flag;
    logic [2:0] cross_axis_fire_bits;
    logic [2:0] sibling_fire_bits;
    logic [4:0] action_select_code;
    logic [3:0] activation_cause_code;
  } set_cfg_type;

  typedef logic [3:0] set_mask_type;

endpackage : sync_action_pkg

/* File: sync_action_set_config.sv */
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "sync_action_params.svh"

module sync_action_set_config
  import sync_action_pkg::*;
#(
  parameter int CAUSES = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [CAUSES-1:0] cause_event,
  input  wire logic              cross_fire_in,
  input  wire logic              error_flag,
  output logic [3:0]             action_fire,
  output logic [3:0]             split_pulse_start,
  output logic [3:0]             drive_start_cause,
  output logic [4:0]             action_code_0,
  output logic [4:0]             action_code_1,
  output logic [4:0]             action_code_2,
  output logic [4:0]             action_code_3,
  output logic [3:0]             set_enabled,
  output logic [2:0]             cross_axis_fire_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0]       write_data_q;
  set_cfg_type [3:0] cfg_q;
  set_mask_type      enable_q;
  set_mask_type      enable_d;
  logic              error_disables_sets_q;
  logic              err_lock_q;
  logic              err_lock_d;
  logic              err_prev_q;
  logic [31:0]       prdata_q;
  logic [3:0]        fire_q;
  logic [3:0]        split_q;
  logic [3:0]        drive_start_q;
  logic [2:0]        cross_q;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle

  function automatic logic [31:0] cfg_offset(input int k);
    return 32'(`OFF_CFG_BASE) + 32'(4 * k);
  endfunction : cfg_offset

  wire logic setup_ph  = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic hit_wdata = (paddr == `OFF_WRITE_DATA);
  wire logic hit_cmd   = (paddr == `OFF_COMMAND);
  wire logic hit_st3   = (paddr == `OFF_STATUS3);
  wire logic hit_bst   = (paddr == `OFF_BLOCK_STATUS);
  wire logic hit_cfg   = (paddr >= `OFF_CFG_BASE) && (paddr <= `OFF_CFG_LAST) && (paddr[1:0] == 2'b00);
  wire logic [1:0] cfg_idx = paddr[3:2];

  // Command register is write only, status and config mirrors are read only
  wire logic rd_ok   = hit_wdata | hit_st3 | hit_bst | hit_cfg;
  wire logic wr_ok   = hit_wdata | hit_cmd;
  wire logic addr_ok = pwrite ? wr_ok : rd_ok;

  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_ok;

  wire logic wr_wdata = access_ph & pwrite & hit_wdata;
  wire logic cmd_vld  = access_ph & pwrite & hit_cmd & pstrb[0];
  wire logic [7:0] cmd_code = pwdata[7:0];
  wire logic [3:0] cmd_hi   = cmd_code[7:4];
  wire logic [3:0] cmd_mask = cmd_code[3:0];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_wdata) begin
      rd_mux = {16'h0000, write_data_q};
    end else if (hit_st3) begin
      rd_mux = {28'h000_0000, enable_q};
    end else if (hit_bst) begin
      rd_mux = {30'h0000_0000, error_disables_sets_q, err_lock_q};
    end else if (hit_cfg) begin
      rd_mux = {16'h0000, cfg_q[cfg_idx]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;

  // Byte lanes 0 and 1 carry the 16-bit write data word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_data_q <= `WDATA_RESET;
    end else if (wr_wdata) begin
      if (pstrb[0]) write_data_q[7:0] <= pwdata[7:0];
      if (pstrb[1]) write_data_q[15:8] <= pwdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire logic cmd_cfg    = cmd_vld && (cmd_code >= `CMD_CFG_BASE) && (cmd_code <= `CMD_CFG_LAST);
  wire logic [1:0] cfg_sel = 2'(cmd_code - `CMD_CFG_BASE);
  wire logic cmd_pin2   = cmd_vld && (cmd_code == `CMD_PIN_CFG2);
  wire logic cmd_errclr = cmd_vld && (cmd_code == `CMD_ERR_CLEAR);

  wire set_mask_type en_mask  = (cmd_vld && cmd_hi == `CMD_ENABLE_HI) ? cmd_mask : 4'h0;
  wire set_mask_type dis_mask = (cmd_vld && cmd_hi == `CMD_DISABLE_HI) ? cmd_mask : 4'h0;
  wire set_mask_type act_mask = (cmd_vld && cmd_hi == `CMD_ACTIVATE_HI) ? cmd_mask : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= {4{`CFG_RESET}};
    end else if (cmd_cfg) begin
      cfg_q[cfg_sel] <= write_data_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_disables_sets_q <= 1'b0;
    end else if (cmd_pin2) begin
      error_disables_sets_q <= write_data_q[`ERROR_DISABLES_SETS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger routing

  logic [3:0] cause_hit;
  logic [3:0] repeat_bits;

  for (genvar k = 0; k < 4; k++) begin : g_set
    cause_select #(
      .CAUSES (CAUSES)
    ) u_cause (
      .cause_code  (cfg_q[k].activation_cause_code),
      .cause_event (cause_event),
      .cause_hit   (cause_hit[k])
    );
    assign repeat_bits[k] = cfg_q[k].repeat_flag;
  end

  // Chaining starts only from a set's own cause, so sibling loops cannot run away
  wire logic [3:0] own_fire = cause_hit & enable_q;
  logic [3:0] sibling_req;
  logic [2:0] cross_req;

  fire_router u_router (
    .own_fire    (own_fire),
    .cfg         (cfg_q),
    .sibling_req (sibling_req),
    .cross_req   (cross_req)
  );

  wire logic [3:0] cross_req_in = {3'b000, cross_fire_in};

  // All trigger sources merge into one bit per set before gating
  wire logic [3:0] any_req = cause_hit | sibling_req | act_mask | cross_req_in;
  wire logic [3:0] fire    = any_req & enable_q;

  // A one-shot set expires on its action; repeating sets are left alone
  wire logic [3:0] expire  = fire & ~repeat_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // Enable state

  // Error flag sampled for its rising edge; a flag stuck high disables once
  wire logic err_rise = error_disables_sets_q & error_flag & ~err_prev_q;

  // Enable commands are dropped while the error lockout stands
  wire set_mask_type en_eff = err_lock_q ? 4'h0 : en_mask;

  // Drive termination has no path here: a repeat loop ends only by a disable command or by an error disable
  always_comb begin
    enable_d = (enable_q & ~dis_mask & ~expire) | en_eff;
    if (err_rise) begin
      enable_d = 4'h0;
    end
  end

  // A new error beats a clear command issued in the same cycle
  assign err_lock_d = err_rise | (err_lock_q & ~cmd_errclr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q   <= `ENABLE_RESET;
      err_lock_q <= 1'b0;
      err_prev_q <= 1'b0;
    end else begin
      enable_q   <= enable_d;
      err_lock_q <= err_lock_d;
      err_prev_q <= error_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [3:0] split_now;
  logic [3:0] drive_now;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      split_now[k] = fire[k] && (cfg_q[k].action_select_code == `ACTION_SPLIT_START);
      drive_now[k] = (cfg_q[k].activation_cause_code == `CAUSE_DRIVE_START);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fire_q        <= 4'h0;
      split_q       <= 4'h0;
      drive_start_q <= 4'h0;
      cross_q       <= 3'h0;
    end else begin
      fire_q        <= fire;
      split_q       <= split_now;
      drive_start_q <= drive_now;
      cross_q       <= cross_req;
    end
  end

  assign action_fire         = fire_q;
  assign split_pulse_start   = split_q;
  assign drive_start_cause   = drive_start_q;
  assign cross_axis_fire_out = cross_q;
  assign set_enabled         = enable_q;
  assign action_code_0       = cfg_q[0].action_select_code;
  assign action_code_1       = cfg_q[1].action_select_code;
  assign action_code_2       = cfg_q[2].action_select_code;
  assign action_code_3       = cfg_q[3].action_select_code;

endmodule : sync_action_set_config

/* File: sync_action_set_config_assertions.sv */
`timescale 1ns/1ps
module sync_action_set_config_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  action_fire,
  input wire logic [3:0]  split_pulse_start,
  input wire logic [3:0]  set_enabled,
  input wire logic [2:0]  cross_axis_fire_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       acc = psel & penable;
  wire       cmd = acc & pwrite & pstrb[0] & (paddr == 8'h04);
  wire [3:0] hi  = pwdata[7:4];
  wire [3:0] msk = pwdata[3:0];
  ////////////////////////////////////////////////////////////
  property p_rise;
    (set_enabled & ~$past(set_enabled)) != 4'h0 |-> $past(cmd) && $past(hi) == 4'h8;
  endproperty
  a_rise: assert property (p_rise) else $error("enable rose without enable command");
  property p_dis;
    cmd && hi == 4'h9 |=> (set_enabled & $past(msk)) == 4'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("masked sets still enabled");
  property p_act;
    cmd && hi == 4'ha |=> (action_fire & $past(msk)) == ($past(msk) & $past(set_enabled));
  endproperty
  a_act: assert property (p_act) else $error("activation fired wrong sets");
  property p_fire;
    (action_fire & ~$past(set_enabled)) == 4'h0;
  endproperty
  a_fire: assert property (p_fire) else $error("disabled set fired");
  property p_stat;
    acc && !pwrite && paddr == 8'h08 |-> prdata[3:0] == $past(set_enabled);
  endproperty
  a_stat: assert property (p_stat) else $error("status bits differ from enables");
  property p_split;
    split_pulse_start != 4'h0 |-> (split_pulse_start & ~action_fire) == 4'h0;
  endproperty
  a_split: assert property (p_split) else $error("split start without fire");
  property p_cross;
    cross_axis_fire_out != 3'h0 |-> action_fire != 4'h0;
  endproperty
  a_cross: assert property (p_cross) else $error("cross fire without own fire");
  property p_ready;
    acc |-> pready && (pslverr == !(pwrite ? (paddr == 8'h00 || paddr == 8'h04)
                                           : (paddr == 8'h00 || paddr == 8'h08 || paddr == 8'h0c ||
                                              paddr == 8'h10 || paddr == 8'h14 || paddr == 8'h18 ||
                                              paddr == 8'h1c)));
  endproperty
  a_ready: assert property (p_ready) else $error("refused access not flagged");
  // Covers show the main traffic really happened
  c_act: cover property (cmd && hi == 4'ha);
  c_pair: cover property (action_fire == 4'h3);
  c_drop: cover property ($fell(set_enabled[0]));
endmodule : sync_action_set_config_assertions
bind sync_action_set_config sync_action_set_config_assertions chk_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .action_fire(action_fire), .split_pulse_start(split_pulse_start),
  .set_enabled(set_enabled), .cross_axis_fire_out(cross_axis_fire_out));

/* File: sync_action_set_config_tb.sv */
`timescale 1ns/1ps
module sync_action_set_config_tb;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] cause_event;
  logic        cross_fire_in;
  logic        error_flag;
  logic [3:0]  action_fire;
  logic [3:0]  split_pulse_start;
  logic [3:0]  drive_start_cause;
  logic [4:0]  action_code [4];
  logic [3:0]  set_enabled;
  logic [2:0]  cross_axis_fire_out;
  logic [31:0] rd;
  logic        rsp;
  int          error_cnt;
  int          cmp_count;
  sync_action_set_config dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cause_event(cause_event), .cross_fire_in(cross_fire_in),
    .error_flag(error_flag), .action_fire(action_fire), .split_pulse_start(split_pulse_start),
    .drive_start_cause(drive_start_cause), .action_code_0(action_code[0]),
    .action_code_1(action_code[1]), .action_code_2(action_code[2]),
    .action_code_3(action_code[3]), .set_enabled(set_enabled),
    .cross_axis_fire_out(cross_axis_fire_out));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends as soon as pready is high, which is on the first access cycle
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rsp = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, 8'h04, {24'h000000, c});
  endtask : cmd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask : rdc
  task automatic cfg(input logic [1:0] k, input logic [15:0] v);
    apb(1'b1, 8'h00, {16'h0000, v});
    cmd(8'h26 + {6'h00, k});
  endtask : cfg
  // Holds the event for exactly one cycle; fire shows right after
  task automatic ev(input logic [15:0] c, input logic x);
    @(posedge pclk);
    cause_event <= c;
    cross_fire_in <= x;
    @(posedge pclk);
    cause_event <= 16'h0000;
    cross_fire_in <= 1'b0;
    #1;
  endtask : ev
  ////////////////////////////////////////////////////////////
  task automatic t_config;
    for (int k = 0; k < 4; k++) begin
      cfg(k[1:0], {7'h00, 5'h17 - k[4:0], 4'h3 ^ k[3:0]});
      rdc(8'h10 + {4'h0, k[1:0], 2'b00}, {23'h0, 5'h17 - k[4:0], 4'h3 ^ k[3:0]});
      chk(action_code[k], 5'h17 - k[4:0]);
    end
    chk(drive_start_cause, 4'h1);
    $display("t_config done");
  endtask : t_config
  task automatic t_enable;
    rdc(8'h08, 32'h0);
    cmd(8'h83);
    chk(rsp, 32'h0);
    rdc(8'h08, 32'h3);
    cmd(8'h88);
    rdc(8'h08, 32'hb);
    cmd(8'h92);
    rdc(8'h08, 32'h9);
    cmd(8'h9f);
    apb(1'b1, 8'h08, 32'hf);
    chk(rsp, 32'h1);
    rdc(8'h08, 32'h0);
    $display("t_enable done");
  endtask : t_enable
  task automatic t_once;
    cfg(2'd0, 16'h0171);
    cfg(2'd3, 16'h8011);
    cmd(8'h89);
    ev(16'h0002, 1'b0);
    chk(action_fire, 4'h9);
    chk(split_pulse_start, 4'h1);
    chk(set_enabled, 4'h8);
    ev(16'h0002, 1'b0);
    chk(action_fire, 4'h8);
    $display("t_once done");
  endtask : t_once
  task automatic t_chain;
    cmd(8'h9f);
    cfg(2'd0, 16'h1222);
    cfg(2'd1, 16'h0030);
    cmd(8'h83);
    ev(16'h0004, 1'b0);
    chk(action_fire, 4'h3);
    chk(cross_axis_fire_out, 3'h1);
    cfg(2'd0, 16'h9222);
    cfg(2'd1, 16'h8032);
    cmd(8'h83);
    ev(16'h0004, 1'b1);
    chk(action_fire, 4'h3);
    @(posedge pclk);
    #1;
    chk(action_fire, 4'h0);
    // Set 0 with a NOP cause fires only from the other axis
    cfg(2'd0, 16'h8050);
    ev(16'h0000, 1'b1);
    chk(action_fire, 4'h1);
    chk(cross_axis_fire_out, 3'h0);
    $display("t_chain done");
  endtask : t_chain
  task automatic t_act;
    cmd(8'h9f);
    cmd(8'h85);
    cmd(8'haf);
    #1;
    chk(action_fire, 4'h5);
    chk(set_enabled, 4'h1);
    $display("t_act done");
  endtask : t_act
  task automatic t_err;
    apb(1'b1, 8'h00, 32'h80);
    cmd(8'h22);
    cmd(8'h8f);
    error_flag <= 1'b1;
    rdc(8'h08, 32'h0);
    cmd(8'h81);
    rdc(8'h08, 32'h0);
    error_flag <= 1'b0;
    cmd(8'h79);
    cmd(8'h81);
    rdc(8'h08, 32'h1);
    $display("t_err done");
  endtask : t_err
  // Reset in mid-run must clear enables, configs and the error option
  task automatic t_reset;
    cmd(8'h8f);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(set_enabled, 4'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h10, 32'h0);
    rdc(8'h0c, 32'h0);
    rdc(8'h08, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, cross_fire_in, error_flag} = 6'h00;
    {paddr, pwdata, cause_event} = 56'h0;
    pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_enable();
    t_config();
    t_once();
    t_chain();
    t_act();
    t_err();
    t_reset();
    close_out();
  end
endmodule : sync_action_set_config_tb
